// >>> hdl/i2c_byte_pkg.sv
package i2c_byte_pkg;
    // register map, word index on the 3-bit port address
    localparam logic [2:0] OFF_STATUS = 3'h0;
    localparam logic [2:0] OFF_TARGET = 3'h1;
    localparam logic [2:0] OFF_RX     = 3'h2;
    localparam logic [2:0] OFF_TX     = 3'h3;
    localparam logic [2:0] OFF_EVENT  = 3'h4;
    localparam logic [2:0] OFF_MASK   = 3'h5;
    // link_status_control fields
    localparam int BIT_STOP_TX = 0;
    localparam int BIT_FAST    = 4;
    localparam int BIT_ERR     = 5;
    localparam int BIT_RIE     = 6;
    localparam int BIT_RXF     = 7;
    // event / mask fields
    localparam int EV_W   = 3;
    localparam int EV_RX  = 0;
    localparam int EV_ERR = 1;
    localparam int EV_TX  = 2;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] EV_RST   = 3'h0;
    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int STD_PERIOD_NS  = 10000;
    localparam int FAST_PERIOD_NS = 2500;
    localparam int QUARTER_DIV    = 4 * CLK_PERIOD_NS;
    // a quarter of the bit time is a least time: round up
    localparam logic [7:0] Q_STD_CYC  = 8'((STD_PERIOD_NS + QUARTER_DIV - 1) / QUARTER_DIV);
    localparam logic [7:0] Q_FAST_CYC = 8'((FAST_PERIOD_NS + QUARTER_DIV - 1) / QUARTER_DIV);
    localparam logic [3:0] ACK_BIT    = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_BIT   = 2'b11,
        ST_STOP  = 2'b10
    } link_state_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;
endpackage

// >>> hdl/i2c_master_byte_port.sv
`timescale 1ns/1ps
// Behaviour
// (R1) slave nack sets error bit 5; writing one clears it, zero leaves it
// (R2) receive-full bit 7 set on byte load, cleared by read; irq gated by bit 6
// (R3) target address bits 7..1 hold seven-bit slave address, reset zero
// (R4) target address bit 0 is direction sent in address byte, 0 write
// (R5) receive byte register is read-only, holds last received byte, reset zero
// (R6) any transmit byte write starts a transfer, address phase when new
// (R7) transmit byte register is eight-bit read/write, reset zero
// (R8) status bit 4 selects 100 kHz when zero, 400 kHz when one
// (R9) single bus master only, no arbitration logic
// (R10) status bit 0 one issues stop after transmitted byte, zero none; here a nacked byte still ends in a stop with bit 0 zero
module i2c_master_byte_port (
    // clock, reset, enable
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    // register port
    input  wire i2c_byte_pkg::bus_req_type  bus_req,
    output logic [7:0]                      rdata,
    output logic                            irq,
    // open-drain link pins
    input  wire logic                       scl_in,
    output logic                            scl_out,
    output logic                            scl_oe,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe
);
    i2c_byte_pkg::link_state_type state_r, state_nxt;
    logic [7:0]  qcnt_r, qcnt_nxt, qlen;
    logic [1:0]  phase_r, phase_nxt;
    logic [3:0]  bitn_r, bitn_nxt;
    logic [7:0]  shift_r, shift_nxt;
    logic        addr_ph_r, addr_ph_nxt;
    logic        rx_mode_r, rx_mode_nxt;
    logic        active_r, active_nxt;
    logic        nack_r, nack_nxt;
    logic        scl_oe_nxt, sda_oe_nxt;
    logic        qend, take, ev_rx, ev_err, ev_tx;
    logic        scl_m_r, scl_s_r, sda_m_r, sda_s_r;
    logic        rxf_r, rxf_nxt, rie_r, rie_nxt, err_r, err_nxt;
    logic        fast_r, fast_nxt, stop_tx_r, stop_tx_nxt, go_r, go_nxt;
    logic [7:0]  target_r, target_nxt, rx_r, rx_nxt, tx_r, tx_nxt, rdata_nxt;
    logic [i2c_byte_pkg::EV_W-1:0] ev_r, ev_nxt, mask_r, mask_nxt;
    logic        irq_nxt, wr, rd;

    // pins come from another domain: two flops before any use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else if (ce) begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    assign qlen = fast_r ? i2c_byte_pkg::Q_FAST_CYC : i2c_byte_pkg::Q_STD_CYC; // see (R8)
    // >= so that a rate change in mid-quarter with the count past the new length ends that quarter at once
    assign qend = (qcnt_r >= qlen - 8'h01);

    // bit engine; it never watches for a lost bus, being the only master, see (R9)
    always_comb begin
        state_nxt   = state_r;
        qcnt_nxt    = qcnt_r;
        phase_nxt   = phase_r;
        bitn_nxt    = bitn_r;
        shift_nxt   = shift_r;
        addr_ph_nxt = addr_ph_r;
        rx_mode_nxt = rx_mode_r;
        active_nxt  = active_r;
        nack_nxt    = nack_r;
        scl_oe_nxt  = scl_oe;
        sda_oe_nxt  = sda_oe;
        take        = 1'b0;
        ev_rx       = 1'b0;
        ev_err      = 1'b0;
        ev_tx       = 1'b0;
        if (ce) begin
            qcnt_nxt = qcnt_r + 8'h01;
            case (state_r)
                i2c_byte_pkg::ST_IDLE: begin
                    qcnt_nxt = 8'h00;
                    if (go_r) begin
                        take      = 1'b1;
                        phase_nxt = 2'h0;
                        bitn_nxt  = 4'h0;
                        if (active_r) begin
                            // bus still held: data byte only
                            shift_nxt   = tx_r; // see (R6)
                            addr_ph_nxt = 1'b0;
                            sda_oe_nxt  = ~tx_r[7];
                            state_nxt   = i2c_byte_pkg::ST_BIT;
                        end else begin
                            shift_nxt   = target_r; // see (R3) (R4) (R6)
                            addr_ph_nxt = 1'b1;
                            rx_mode_nxt = target_r[0]; // see (R4)
                            sda_oe_nxt  = 1'b0;
                            state_nxt   = i2c_byte_pkg::ST_START;
                        end
                    end
                end
                i2c_byte_pkg::ST_START: begin
                    if (qend) begin
                        qcnt_nxt  = 8'h00;
                        phase_nxt = phase_r + 2'h1;
                        case (phase_r)
                            2'h0: sda_oe_nxt = 1'b1;
                            2'h2: scl_oe_nxt = 1'b1;
                            2'h3: begin
                                sda_oe_nxt = ~shift_r[7];
                                state_nxt  = i2c_byte_pkg::ST_BIT;
                            end
                            default: ;
                        endcase
                    end
                end
                i2c_byte_pkg::ST_BIT: begin
                    if (phase_r == 2'h1 && !scl_s_r) begin
                        // slave holds the clock low: stretch the high phase
                        qcnt_nxt = 8'h00;
                    end else if (qend) begin
                        qcnt_nxt  = 8'h00;
                        phase_nxt = phase_r + 2'h1;
                        case (phase_r)
                            2'h0: scl_oe_nxt = 1'b0;
                            2'h1: begin
                                if (bitn_r == i2c_byte_pkg::ACK_BIT) begin
                                    nack_nxt = sda_s_r;
                                end else begin
                                    shift_nxt = {shift_r[6:0], sda_s_r};
                                end
                            end
                            2'h2: scl_oe_nxt = 1'b1;
                            default: begin
                                bitn_nxt   = bitn_r + 4'h1;
                                // reads always end with nack, so ack slot is released
                                sda_oe_nxt = (bitn_r < 4'h7) && !(rx_mode_r && !addr_ph_r)
                                             && !shift_r[7];
                                if (bitn_r == i2c_byte_pkg::ACK_BIT) begin
                                    bitn_nxt = 4'h0;
                                    if (addr_ph_r && !nack_r) begin
                                        addr_ph_nxt = 1'b0;
                                        shift_nxt   = tx_r;
                                        sda_oe_nxt  = !rx_mode_r && !tx_r[7];
                                    end else if (rx_mode_r && !addr_ph_r) begin
                                        ev_rx      = 1'b1; // see (R2) (R5)
                                        sda_oe_nxt = 1'b1;
                                        state_nxt  = i2c_byte_pkg::ST_STOP;
                                    end else if (nack_r) begin
                                        ev_err     = 1'b1; // see (R1)
                                        sda_oe_nxt = 1'b1;
                                        state_nxt  = i2c_byte_pkg::ST_STOP;
                                    end else if (stop_tx_r) begin
                                        ev_tx      = 1'b1;
                                        sda_oe_nxt = 1'b1;
                                        state_nxt  = i2c_byte_pkg::ST_STOP; // see (R10)
                                    end else begin
                                        // keep the clock low and the bus owned
                                        ev_tx      = 1'b1;
                                        sda_oe_nxt = 1'b0;
                                        active_nxt = 1'b1;
                                        state_nxt  = i2c_byte_pkg::ST_IDLE; // see (R10)
                                    end
                                end
                            end
                        endcase
                    end
                end
                default: begin
                    if (phase_r == 2'h1 && !scl_s_r) begin
                        // a slave still stretching the clock would swallow the stop
                        qcnt_nxt = 8'h00;
                    end else if (qend) begin
                        qcnt_nxt  = 8'h00;
                        phase_nxt = phase_r + 2'h1;
                        case (phase_r)
                            2'h0: scl_oe_nxt = 1'b0;
                            2'h1: sda_oe_nxt = 1'b0;
                            2'h3: begin
                                active_nxt = 1'b0;
                                state_nxt  = i2c_byte_pkg::ST_IDLE;
                            end
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= i2c_byte_pkg::ST_IDLE;
            qcnt_r    <= 8'h00;
            phase_r   <= 2'h0;
            bitn_r    <= 4'h0;
            shift_r   <= i2c_byte_pkg::BYTE_RST;
            addr_ph_r <= 1'b0;
            rx_mode_r <= 1'b0;
            active_r  <= 1'b0;
            nack_r    <= 1'b0;
            scl_oe    <= 1'b0;
            sda_oe    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            qcnt_r    <= qcnt_nxt;
            phase_r   <= phase_nxt;
            bitn_r    <= bitn_nxt;
            shift_r   <= shift_nxt;
            addr_ph_r <= addr_ph_nxt;
            rx_mode_r <= rx_mode_nxt;
            active_r  <= active_nxt;
            nack_r    <= nack_nxt;
            scl_oe    <= scl_oe_nxt;
            sda_oe    <= sda_oe_nxt;
        end
    end

    assign wr = bus_req.wr & ce;
    assign rd = bus_req.rd & ce;

    // registers: clears first, hardware sets last so a set always wins
    always_comb begin
        rxf_nxt     = rxf_r;
        rie_nxt     = rie_r;
        err_nxt     = err_r;
        fast_nxt    = fast_r;
        stop_tx_nxt = stop_tx_r;
        go_nxt      = go_r;
        target_nxt  = target_r;
        rx_nxt      = rx_r;
        tx_nxt      = tx_r;
        ev_nxt      = ev_r;
        mask_nxt    = mask_r;
        rdata_nxt   = ce ? 8'h00 : rdata;
        if (take) begin
            go_nxt = 1'b0;
        end
        if (wr) begin
            case (bus_req.addr)
                i2c_byte_pkg::OFF_STATUS: begin
                    rie_nxt     = bus_req.wdata[i2c_byte_pkg::BIT_RIE];
                    fast_nxt    = bus_req.wdata[i2c_byte_pkg::BIT_FAST]; // see (R8)
                    stop_tx_nxt = bus_req.wdata[i2c_byte_pkg::BIT_STOP_TX]; // see (R10)
                    if (bus_req.wdata[i2c_byte_pkg::BIT_ERR]) begin
                        err_nxt = 1'b0; // see (R1)
                    end
                end
                i2c_byte_pkg::OFF_TARGET: target_nxt = bus_req.wdata; // see (R3) (R4)
                i2c_byte_pkg::OFF_TX: begin
                    tx_nxt = bus_req.wdata; // see (R7)
                    go_nxt = 1'b1; // see (R6)
                end
                i2c_byte_pkg::OFF_MASK: mask_nxt = bus_req.wdata[i2c_byte_pkg::EV_W-1:0];
                default: ;
            endcase
        end
        if (rd) begin
            case (bus_req.addr)
                i2c_byte_pkg::OFF_STATUS:
                    rdata_nxt = {rxf_r, rie_r, err_r, fast_r, 3'h0, stop_tx_r};
                i2c_byte_pkg::OFF_TARGET: rdata_nxt = target_r;
                i2c_byte_pkg::OFF_RX: begin
                    rdata_nxt = rx_r; // see (R5)
                    rxf_nxt   = 1'b0; // see (R2)
                end
                i2c_byte_pkg::OFF_TX: rdata_nxt = tx_r; // see (R7)
                i2c_byte_pkg::OFF_EVENT: begin
                    rdata_nxt = {5'h00, ev_r};
                    ev_nxt    = i2c_byte_pkg::EV_RST;
                end
                i2c_byte_pkg::OFF_MASK: rdata_nxt = {5'h00, mask_r};
                default: ;
            endcase
        end
        if (ev_rx) begin
            rxf_nxt                   = 1'b1; // see (R2)
            rx_nxt                    = shift_r; // see (R5)
            ev_nxt[i2c_byte_pkg::EV_RX] = 1'b1;
        end
        if (ev_err) begin
            err_nxt                    = 1'b1; // see (R1)
            ev_nxt[i2c_byte_pkg::EV_ERR] = 1'b1;
        end
        if (ev_tx) begin
            ev_nxt[i2c_byte_pkg::EV_TX] = 1'b1;
        end
        irq_nxt = (|(ev_nxt & mask_nxt)) | (rxf_nxt & rie_nxt); // see (R2)
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxf_r     <= 1'b0;
            rie_r     <= 1'b0;
            err_r     <= 1'b0;
            fast_r    <= 1'b0;
            stop_tx_r <= 1'b0;
            go_r      <= 1'b0;
            target_r  <= i2c_byte_pkg::BYTE_RST;
            rx_r      <= i2c_byte_pkg::BYTE_RST;
            tx_r      <= i2c_byte_pkg::BYTE_RST;
            ev_r      <= i2c_byte_pkg::EV_RST;
            mask_r    <= i2c_byte_pkg::EV_RST;
            rdata     <= i2c_byte_pkg::BYTE_RST;
            irq       <= 1'b0;
        end else begin
            rxf_r     <= rxf_nxt;
            rie_r     <= rie_nxt;
            err_r     <= err_nxt;
            fast_r    <= fast_nxt;
            stop_tx_r <= stop_tx_nxt;
            go_r      <= go_nxt;
            target_r  <= target_nxt;
            rx_r      <= rx_nxt;
            tx_r      <= tx_nxt;
            ev_r      <= ev_nxt;
            mask_r    <= mask_nxt;
            rdata     <= rdata_nxt;
            irq       <= irq_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_tx_write;
        wr && bus_req.addr == i2c_byte_pkg::OFF_TX;
    endsequence
    sequence s_new_take;
        take && !active_r;
    endsequence

    a_err_set: assert property (ev_err |=> err_r) // see (R1)
        else $error("nack did not raise the error bit");
    a_err_keep: assert property (wr && bus_req.addr == i2c_byte_pkg::OFF_STATUS
        && !bus_req.wdata[i2c_byte_pkg::BIT_ERR] && err_r |=> err_r) // see (R1)
        else $error("writing zero cleared the error bit");
    a_rxf_clear: assert property (rd && bus_req.addr == i2c_byte_pkg::OFF_RX && !ev_rx
        |=> !rxf_r && rdata == $past(rx_r)) // see (R2)
        else $error("receive read did not clear the full flag");
    a_rx_load: assert property (ev_rx |=> rxf_r && rx_r == $past(shift_r)) // see (R5)
        else $error("received byte not loaded");
    a_addr_send: assert property (s_new_take |=> state_r == i2c_byte_pkg::ST_START
        && shift_r == $past(target_r)) // see (R3)
        else $error("address byte not loaded for new transaction");
    a_dir_bit: assert property (s_new_take |=> rx_mode_r == $past(target_r[0])) // see (R4)
        else $error("direction not taken from target bit 0");
    a_tx_start: assert property (s_tx_write ##1 (state_r == i2c_byte_pkg::ST_IDLE && ce)
        |=> state_r != i2c_byte_pkg::ST_IDLE) // see (R6)
        else $error("transmit write did not start a transfer");
    a_rate_sel: assert property (fast_r && $past(fast_r) // see (R8)
        |-> qcnt_r < i2c_byte_pkg::Q_FAST_CYC)
        else $error("quarter counter exceeds the fast rate");
    a_rate_cap: assert property (qcnt_r < i2c_byte_pkg::Q_STD_CYC) // see (R8)
        else $error("quarter counter exceeds the standard rate");
    a_stop_sel: assert property (ev_tx |=> (state_r == i2c_byte_pkg::ST_STOP) == $past(stop_tx_r)) // see (R10)
        else $error("stop after transmit not as selected");
    a_tx_hold: assert property (s_tx_write |=> tx_r == $past(bus_req.wdata) && go_r) // see (R7)
        else $error("transmit byte not stored");
endmodule // i2c_master_byte_port

// >>> sim/i2c_slave_model.sv
`timescale 1ns/1ps
module i2c_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h5A
) (
    // bus wires
    input  wire logic        scl,
    input  wire logic        sda,
    // behaviour
    input  wire logic [7:0]  tx_byte,
    input  wire logic [31:0] stretch_ns,
    // pulls and record
    output logic             scl_low,
    output logic             sda_low,
    output logic [7:0]       last_addr,
    output logic [7:0]       last_data,
    output logic             last_mack,
    output int               starts,
    output int               stops
);
    int start_cnt = 0;
    int stop_cnt  = 0;
    assign starts = start_cnt;
    assign stops  = stop_cnt;
    always @(posedge sda) if (scl === 1'b1) stop_cnt++;
    task automatic get_byte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            @(posedge scl);
            v[i] = sda;
        end
    endtask
    task automatic ack(input logic yes, input logic lead);
        @(negedge scl);
        sda_low = yes;
        @(negedge scl);
        // a read's first bit goes out here, while the clock is still low
        sda_low = lead;
        // slow answer: hold the clock low past the ack bit
        if (stretch_ns > 0) begin
            scl_low = 1'b1;
            #(stretch_ns);
            scl_low = 1'b0;
        end
    endtask
    task automatic transfer();
        logic [7:0] v;
        get_byte(v);
        last_addr = v;
        ack(v[7:1] == DEV_ADDR, v[7:1] == DEV_ADDR && v[0] && !tx_byte[7]);
        if (v[7:1] == DEV_ADDR && v[0]) begin
            for (int i = 7; i >= 0; i--) begin
                sda_low = !tx_byte[i];
                @(negedge scl);
            end
            sda_low = 1'b0;
            @(posedge scl);
            last_mack = sda;
        end else if (v[7:1] == DEV_ADDR) begin
            // held bus: keep taking data bytes until a stop ends the frame
            forever begin
                get_byte(v);
                last_data = v;
                ack(1'b1, 1'b0);
            end
        end
    endtask
    initial begin
        scl_low   = 1'b0;
        sda_low   = 1'b0;
        last_addr = 8'h00;
        last_data = 8'h00;
        last_mack = 1'b0;
        forever begin
            @(negedge sda iff scl === 1'b1);
            start_cnt++;
            fork
                transfer();
                @(posedge sda iff scl === 1'b1);
            join_any
            disable fork;
            sda_low = 1'b0;
            scl_low = 1'b0;
        end
    end
endmodule // i2c_slave_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] DEV = 7'h5A;
    logic                      core_clk = 1'b0;
    logic                      rst_n = 1'b0;
    logic                      ce = 1'b1;
    i2c_byte_pkg::bus_req_type bus_req = '0;
    logic [7:0]                rdata, last_addr, last_data, rv, d;
    logic [7:0]                mtx = 8'h00;
    logic                      irq, scl_out, scl_oe, sda_out, sda_oe;
    logic                      scl_low, sda_low, last_mack;
    logic [31:0]               stretch_ns = 32'h0;
    logic [15:0]               seed = 16'hFB07;
    int                        starts, stops, s0, n0, n, t0;
    int                        fail_count = 0;
    int                        tests_run = 0;
    wire                       scl = !(scl_oe | scl_low);
    wire                       sda = !(sda_oe | sda_low);
    always #5 core_clk = ~core_clk;
    i2c_master_byte_port DUT (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
        .rdata(rdata), .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
    i2c_slave_model #(.DEV_ADDR(DEV)) slave (.scl(scl), .sda(sda), .tx_byte(mtx),
        .stretch_ns(stretch_ns), .scl_low(scl_low), .sda_low(sda_low), .last_addr(last_addr),
        .last_data(last_data), .last_mack(last_mack), .starts(starts), .stops(stops));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic tick(input int k);
        if (k >= 40000) begin
            fail_count++;
            $display("[FAIL] wait expected done seen timeout");
            report_and_stop();
        end
        @(posedge core_clk);
    endtask
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0] ^ seed[15:8];
    endfunction
    // expected status byte from {rxf, rie, err, fast, stop}; bits 3..1 read zero
    function automatic logic [7:0] stat(input logic [4:0] f);
        return {f[4:1], 3'h0, f[0]};
    endfunction
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_irq();
        for (n = 0; irq !== 1'b1; n++) tick(n);
    endtask
    task automatic wait_stop();
        for (n = 0; stops == s0; n++) tick(n);
    endtask
    task automatic scl_period(input int lo, input int hi);
        for (n = 0; scl !== 1'b0; n++) tick(n);
        for (n = 0; scl !== 1'b1; n++) tick(n);
        t0 = $time;
        for (n = 0; scl !== 1'b0; n++) tick(n);
        for (n = 0; scl !== 1'b1; n++) tick(n);
        chk_bit("scl period", 1'b1, ($time - t0) >= lo && ($time - t0) <= hi);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            rd(3'(a), rv);
            chk_byte("reset value", 8'h00, rv);
        end
        chk_bit("pin outputs", 1'b0, scl_out | sda_out);
        d = rnd();
        wr(i2c_byte_pkg::OFF_TARGET, d);
        rd(i2c_byte_pkg::OFF_TARGET, rv);
        chk_byte("target", d, rv);
        wr(i2c_byte_pkg::OFF_RX, d);
        rd(i2c_byte_pkg::OFF_RX, rv);
        chk_byte("rx read only", 8'h00, rv);
        @(posedge core_clk);
        ce <= 1'b0;
        wr(i2c_byte_pkg::OFF_TARGET, ~d);
        ce <= 1'b1;
        rd(i2c_byte_pkg::OFF_TARGET, rv);
        chk_byte("frozen target", d, rv);
        wr(i2c_byte_pkg::OFF_STATUS, 8'h5F);
        rd(i2c_byte_pkg::OFF_STATUS, rv);
        chk_byte("status", stat(5'b01011), rv);
        $display("test registers done");
        wr(i2c_byte_pkg::OFF_MASK, 8'h04);
        wr(i2c_byte_pkg::OFF_TARGET, {DEV, 1'b0});
        d = rnd();
        s0 = stops;
        wr(i2c_byte_pkg::OFF_TX, d);
        scl_period(2520, 2620);
        wait_irq();
        rd(i2c_byte_pkg::OFF_EVENT, rv);
        chk_byte("tx event", 8'h04, rv);
        @(posedge core_clk);
        #1 chk_bit("irq cleared", 1'b0, irq);
        wait_stop();
        chk_byte("address byte", {DEV, 1'b0}, last_addr);
        chk_byte("data byte", d, last_data);
        rd(i2c_byte_pkg::OFF_TX, rv);
        chk_byte("tx readback", d, rv);
        $display("test write done");
        stretch_ns = 32'd3000;
        wr(i2c_byte_pkg::OFF_STATUS, 8'h10);
        s0 = stops;
        n0 = starts;
        d = rnd();
        wr(i2c_byte_pkg::OFF_TX, d);
        wait_irq();
        rd(i2c_byte_pkg::OFF_EVENT, rv);
        chk_byte("held event", 8'h04, rv);
        repeat (500) @(posedge core_clk);
        chk_bit("no stop", 1'b1, stops == s0);
        chk_byte("held first", d, last_data);
        wr(i2c_byte_pkg::OFF_STATUS, 8'h11);
        d = rnd();
        wr(i2c_byte_pkg::OFF_TX, d);
        wait_irq();
        rd(i2c_byte_pkg::OFF_EVENT, rv);
        chk_byte("held last event", 8'h04, rv);
        wait_stop();
        chk_byte("held data", d, last_data);
        chk_bit("one start", 1'b1, starts == n0 + 1);
        $display("test held bus done");
        wr(i2c_byte_pkg::OFF_MASK, 8'h00);
        wr(i2c_byte_pkg::OFF_STATUS, 8'h50);
        wr(i2c_byte_pkg::OFF_TARGET, {DEV, 1'b1});
        mtx = rnd();
        s0 = stops;
        wr(i2c_byte_pkg::OFF_TX, 8'hA5);
        wait_irq();
        rd(i2c_byte_pkg::OFF_STATUS, rv);
        chk_byte("rx full", stat(5'b11010), rv);
        rd(i2c_byte_pkg::OFF_RX, rv);
        chk_byte("rx byte", mtx, rv);
        rd(i2c_byte_pkg::OFF_STATUS, rv);
        chk_byte("rx empty", stat(5'b01010), rv);
        chk_bit("irq after read", 1'b0, irq);
        rd(i2c_byte_pkg::OFF_EVENT, rv);
        chk_byte("rx event", 8'h01, rv);
        wait_stop();
        chk_bit("master nack", 1'b1, last_mack);
        $display("test read done");
        stretch_ns = 32'd0;
        wr(i2c_byte_pkg::OFF_STATUS, 8'h00);
        wr(i2c_byte_pkg::OFF_TARGET, {DEV ^ 7'h01, 1'b0});
        s0 = stops;
        wr(i2c_byte_pkg::OFF_TX, 8'h3C);
        scl_period(10000, 10100);
        wait_stop();
        chk_bit("irq masked", 1'b0, irq);
        rd(i2c_byte_pkg::OFF_STATUS, rv);
        chk_byte("error set", stat(5'b00100), rv);
        wr(i2c_byte_pkg::OFF_STATUS, 8'h00);
        rd(i2c_byte_pkg::OFF_STATUS, rv);
        chk_byte("zero keeps error", stat(5'b00100), rv);
        wr(i2c_byte_pkg::OFF_STATUS, 8'h20);
        rd(i2c_byte_pkg::OFF_STATUS, rv);
        chk_byte("one clears error", 8'h00, rv);
        rd(i2c_byte_pkg::OFF_EVENT, rv);
        chk_byte("error event", 8'h02, rv);
        $display("test nack done");
        report_and_stop();
    end
endmodule // tb_top
